// >>> rdcc_pkg.sv
// Constants, register map and enumerations of the relay driver command controller
package rdcc_pkg;

  // ==========================================================================
  // APB register map (byte addresses)
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_RESP = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // Status register fields
  localparam int STAT_CMD_RDY_BIT = 0;
  localparam int STAT_RESP_VLD_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_EN_BIT = 3;

  // Interrupt status and mask fields
  localparam int IRQ_W = 2;
  localparam int IRQ_RESP_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;

  // ==========================================================================
  // Driver organisation
  localparam int NUM_DRV = 72;
  localparam int NUM_BANK = 10;
  localparam int BANK_W = 8;
  localparam int NUM_HEX = 18;
  localparam int NUM_REL_LED = 10;
  localparam int SEL_W = 3;

  // ==========================================================================
  // Characters and command tokens
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] TOK_R = 8'h52;
  localparam logic [7:0] TOK_E = 8'h45;
  localparam logic [7:0] TOK_D = 8'h44;
  localparam logic [7:0] TOK_S = 8'h53;
  localparam logic [7:0] TOK_C = 8'h43;
  localparam logic [7:0] TOK_O = 8'h4f;
  localparam logic [15:0] TOK_BANK_CLOSE = 16'h4342;
  localparam logic [23:0] TOK_ERR_QUERY = 24'h514552;
  localparam logic [23:0] TOK_EN_QUERY = 24'h51454e;
  localparam logic [23:0] TOK_RB_QUERY = 24'h515242;
  localparam logic [23:0] TOK_TRIG_QUERY = 24'h515447;

  // Response texts, first character in the top byte
  localparam logic [71:0] TXT_NOERR = 72'h4e4f204552524f5253;
  localparam logic [71:0] TXT_ERR = 72'h434d44204552524f52;
  localparam logic [39:0] TXT_READY = 40'h5245414459;
  localparam logic [111:0] TXT_FAIL = 112'h53454c46205445535420464149 << 8 | 112'h4c;
  localparam logic [4:0] LEN_NOERR = 5'h09;
  localparam logic [4:0] LEN_ERR = 5'h09;
  localparam logic [4:0] LEN_ONE = 5'h01;
  localparam logic [4:0] LEN_RB = 5'h12;
  localparam logic [4:0] LEN_READY = 5'h05;
  localparam logic [4:0] LEN_FAIL = 5'h0e;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int LAMP_FLASH_NS = 500000000;
  localparam int LAMP_FLASH_CYC = LAMP_FLASH_NS / CLK_PERIOD_NS;
  localparam int FLASH_W = 26;

  // ==========================================================================
  // Enumerations
  typedef enum logic [2:0] {
    RSP_NONE, RSP_NOERR, RSP_ERR, RSP_EN, RSP_RB, RSP_TRIG, RSP_READY, RSP_FAIL
  } rdcc_resp_type;

  typedef enum logic [3:0] {
    X_NONE, X_RST, X_EN, X_DIS, X_BANK, X_CLOSE, X_OPEN, X_SELF,
    X_ERR_Q, X_EN_Q, X_RB_Q, X_TRIG_Q, X_BAD
  } rdcc_exec_type;

endpackage

// >>> rdcc_sync.sv
// Two-flop synchroniser for pins entering the controller's clock domain
`timescale 1ns/100ps
`default_nettype none
module rdcc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule
`default_nettype wire

// >>> rdcc_top.sv
// Relay driver command controller: APB word-serial link, command parser, drivers and panel
//
// Overview of operation
// - After power-up the error query answers the no-error text.
// - After power-up outputs are disabled and the enable query reports zero.
// - After power-up the trigger query reports zero.
// - Reset command lights message indicator about half a second, then only power and the display-count weight indicators.
// - Unrecognised command lights error; only error and power lit until reset.
// - Enable command lights enable indicator; other lamps keep their state.
// - Disabled with banks 0 and 1 closed lights relay indicators 0 to 9.
// - Display-select button advances a wrapping three-bit counter on weight indicators.
// - Self-test answers the ready text, or a failure text on failure.
// - While disabled, closed drivers stay off; close state kept for enable.
// - Enable makes closed drivers conduct; readback shows closed bits.
// - Open command with index n clears only driver n.
// - 72 drivers in banks of eight; close-bank takes bank 0 to 9 (bank 9 closes none), open takes driver.
// - Commands end in line feed, optional carriage return; answers end CR LF.
// - Characters pass through communication registers with a polling handshake.
`timescale 1ns/100ps
`default_nettype none
module rdcc_top #(
  parameter int unsigned FLASH_CYC = rdcc_pkg::LAMP_FLASH_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  // Drivers and their sense feedback
  output logic [rdcc_pkg::NUM_DRV-1:0] relay_drive_o,
  input wire logic [rdcc_pkg::NUM_DRV-1:0] drv_sense_i,
  // Front panel
  input wire logic display_select_button_i,
  output logic power_indicator_o,
  output logic message_indicator_o,
  output logic error_indicator_o,
  output logic enable_indicator_o,
  output logic [rdcc_pkg::NUM_REL_LED-1:0] relay_status_indicator_o,
  output logic display_count_bit_weight1_o,
  output logic display_count_bit_weight2_o,
  output logic display_count_bit_weight4_o
);
  import rdcc_pkg::*;

  // ==========================================================================
  // Declarations
  logic [7:0] cmd_char_q;
  logic cmd_pend_q;
  logic [23:0] tok_q;
  logic [1:0] tok_n_q;
  logic tok_bad_q;
  logic [6:0] num_q;
  logic num_seen_q;
  logic [NUM_DRV-1:0] closed_q;
  logic enabled_q;
  logic err_q;
  rdcc_resp_type resp_kind_q;
  logic [4:0] resp_idx_q;
  logic [7:0] resp_data_q;
  logic resp_vld_q;
  logic [FLASH_W-1:0] flash_q;
  logic [SEL_W-1:0] sel_q;
  logic btn_prev_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic btn_s;
  logic [NUM_DRV-1:0] sense_s;
  logic [7:0] up_ch;
  logic is_term;
  logic is_digit;
  logic is_letter;
  logic fire;
  rdcc_exec_type xk;
  logic cmd_rdy;
  logic wr_acc;
  logic rd_acc;
  logic pop;
  logic press;
  logic [4:0] resp_len;
  logic [7:0] resp_ch;
  logic [NUM_DRV-1:0] onehot;
  logic [79:0] led_view;

  // ==========================================================================
  // Pin synchronisers
  rdcc_sync #(.W(1)) u_btn_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(display_select_button_i),
    .q_o(btn_s)
  );

  rdcc_sync #(.W(NUM_DRV)) u_sense_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(drv_sense_i),
    .q_o(sense_s)
  );

  // ==========================================================================
  // Word-serial handshake over APB
  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign rd_acc = psel_i & penable_i & ~pwrite_i;
  assign cmd_rdy = (resp_kind_q == RSP_NONE) & ~cmd_pend_q;
  assign pop = rd_acc & (paddr_i == ADDR_RESP) & resp_vld_q;

  // Command character mailbox; a write while busy is dropped
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cmd_pend_q <= 1'b0;
      cmd_char_q <= 8'h00;
    end else if (wr_acc && paddr_i == ADDR_CMD && pstrb_i[0] && cmd_rdy) begin
      cmd_pend_q <= 1'b1;
      cmd_char_q <= pwdata_i[7:0];
    end else begin
      cmd_pend_q <= 1'b0;
    end
  end

  // Read data and error are sampled in the setup phase so they come from flops
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
      pready_o <= 1'b0;
    end else begin
      pready_o <= 1'b1;
      if (psel_i && !penable_i) begin
        prdata_o <= 32'h0000_0000;
        pslverr_o <= 1'b0;
        unique case (paddr_i)
          ADDR_CMD: prdata_o <= 32'h0000_0000;
          ADDR_RESP: prdata_o <= {24'h00_0000, resp_data_q};
          ADDR_STAT: begin
            prdata_o[STAT_CMD_RDY_BIT] <= cmd_rdy;
            prdata_o[STAT_RESP_VLD_BIT] <= resp_vld_q;
            prdata_o[STAT_ERR_BIT] <= err_q;
            prdata_o[STAT_EN_BIT] <= enabled_q;
          end
          ADDR_IRQ_STAT: prdata_o[IRQ_W-1:0] <= irq_stat_q;
          ADDR_IRQ_MASK: prdata_o[IRQ_W-1:0] <= irq_mask_q;
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================================
  // Character classes; lower case folds to upper
  assign up_ch = (cmd_char_q >= 8'h61 && cmd_char_q <= 8'h7a) ? (cmd_char_q & 8'hdf) : cmd_char_q;
  assign is_term = (up_ch == CH_LF) || (up_ch == CH_SEMI);
  assign is_digit = (up_ch >= CH_0) && (up_ch <= 8'h39);
  assign is_letter = (up_ch >= CH_A) && (up_ch <= 8'h5a);
  assign fire = cmd_pend_q & is_term;

  // Token collector; carriage return and spaces are skipped
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || fire) begin
      tok_q <= 24'h00_0000;
      tok_n_q <= 2'h0;
      tok_bad_q <= 1'b0;
      num_q <= 7'h00;
      num_seen_q <= 1'b0;
    end else if (cmd_pend_q && up_ch != CH_CR && up_ch != CH_SP) begin
      if (is_digit) begin
        num_seen_q <= 1'b1;
        // Saturate so long numbers still read as out of range
        num_q <= (num_q > 7'd11) ? 7'h7f : 7'(num_q * 7'd10 + 7'(up_ch - CH_0));
      end else if (is_letter && !num_seen_q && tok_n_q != 2'h3) begin
        tok_q <= {tok_q[15:0], up_ch};
        tok_n_q <= tok_n_q + 2'h1;
      end else begin
        tok_bad_q <= 1'b1;
      end
    end
  end

  // Decode of the collected command at its terminator
  always_comb begin
    xk = X_BAD;
    if (tok_bad_q) begin
      xk = X_BAD;
    end else if (tok_n_q == 2'h0 && !num_seen_q) begin
      xk = X_NONE;
    end else if (tok_n_q == 2'h1 && !num_seen_q) begin
      if (tok_q[7:0] == TOK_R) xk = X_RST;
      else if (tok_q[7:0] == TOK_E) xk = X_EN;
      else if (tok_q[7:0] == TOK_D) xk = X_DIS;
      else if (tok_q[7:0] == TOK_S) xk = X_SELF;
    end else if (tok_n_q == 2'h1 && num_q < 7'(NUM_DRV)) begin
      if (tok_q[7:0] == TOK_C) xk = X_CLOSE;
      else if (tok_q[7:0] == TOK_O) xk = X_OPEN;
    end else if (tok_n_q == 2'h2 && num_seen_q && tok_q[15:0] == TOK_BANK_CLOSE && num_q < 7'(NUM_BANK)) begin
      xk = X_BANK;
    end else if (tok_n_q == 2'h3 && !num_seen_q) begin
      if (tok_q == TOK_ERR_QUERY) xk = X_ERR_Q;
      else if (tok_q == TOK_EN_QUERY) xk = X_EN_Q;
      else if (tok_q == TOK_RB_QUERY) xk = X_RB_Q;
      else if (tok_q == TOK_TRIG_QUERY) xk = X_TRIG_Q;
    end
  end

  // ==========================================================================
  // Driver state: close state is kept whatever the enable
  assign onehot = NUM_DRV'(1) << num_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      closed_q <= '0;
    end else if (fire) begin
      unique case (xk)
        X_RST: closed_q <= '0;
        X_BANK: closed_q <= closed_q | (NUM_DRV'(8'hff) << (num_q * 7'(BANK_W)));
        X_CLOSE: closed_q <= closed_q | onehot;
        X_OPEN: closed_q <= closed_q & ~onehot;
        default: closed_q <= closed_q;
      endcase
    end
  end

  // Global enable gate, off from power-up
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      enabled_q <= 1'b0;
    end else if (fire && (xk == X_RST || xk == X_DIS)) begin
      enabled_q <= 1'b0;
    end else if (fire && xk == X_EN) begin
      enabled_q <= 1'b1;
    end
  end

  // Drivers conduct only while enabled
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      relay_drive_o <= '0;
    end else begin
      relay_drive_o <= closed_q & {NUM_DRV{enabled_q}};
    end
  end

  // Error latch, clear at power-up, cleared only by the reset command
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
    end else if (fire && xk == X_BAD) begin
      err_q <= 1'b1;
    end else if (fire && xk == X_RST) begin
      err_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Response text generator
  always_comb begin
    unique case (resp_kind_q)
      RSP_NOERR: resp_len = LEN_NOERR;
      RSP_ERR: resp_len = LEN_ERR;
      RSP_RB: resp_len = LEN_RB;
      RSP_READY: resp_len = LEN_READY;
      RSP_FAIL: resp_len = LEN_FAIL;
      default: resp_len = LEN_ONE;
    endcase
  end

  always_comb begin
    logic [3:0] nib;
    nib = 4'(closed_q >> (7'(NUM_HEX - 1 - int'(resp_idx_q)) * 7'h04));
    if (resp_idx_q == resp_len) begin
      resp_ch = CH_CR;
    end else if (resp_idx_q > resp_len) begin
      resp_ch = CH_LF;
    end else begin
      unique case (resp_kind_q)
        RSP_NOERR: resp_ch = TXT_NOERR[8 * (LEN_NOERR - 5'h01 - resp_idx_q) +: 8];
        RSP_ERR: resp_ch = TXT_ERR[8 * (LEN_ERR - 5'h01 - resp_idx_q) +: 8];
        RSP_EN: resp_ch = enabled_q ? CH_1 : CH_0;
        RSP_TRIG: resp_ch = CH_0;
        RSP_READY: resp_ch = TXT_READY[8 * (LEN_READY - 5'h01 - resp_idx_q) +: 8];
        RSP_FAIL: resp_ch = TXT_FAIL[8 * (LEN_FAIL - 5'h01 - resp_idx_q) +: 8];
        RSP_RB: resp_ch = (nib < 4'ha) ? (CH_0 + 8'(nib)) : (CH_A + 8'(nib - 4'ha));
        default: resp_ch = CH_0;
      endcase
    end
  end

  // One character is offered at a time; a read of it fetches the next
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      resp_kind_q <= RSP_NONE;
      resp_idx_q <= 5'h00;
      resp_vld_q <= 1'b0;
      resp_data_q <= 8'h00;
    end else if (fire && resp_kind_q == RSP_NONE) begin
      resp_idx_q <= 5'h00;
      unique case (xk)
        X_ERR_Q: resp_kind_q <= err_q ? RSP_ERR : RSP_NOERR;
        X_EN_Q: resp_kind_q <= RSP_EN;
        X_RB_Q: resp_kind_q <= RSP_RB;
        X_TRIG_Q: resp_kind_q <= RSP_TRIG;
        // Self test: every sensed driver level must match what is driven
        X_SELF: resp_kind_q <= (sense_s != relay_drive_o) ? RSP_FAIL : RSP_READY;
        default: resp_kind_q <= RSP_NONE;
      endcase
    end else if (pop) begin
      resp_vld_q <= 1'b0;
      resp_idx_q <= resp_idx_q + 5'h01;
      if (resp_idx_q > resp_len) begin
        resp_kind_q <= RSP_NONE;
      end
    end else if (resp_kind_q != RSP_NONE && !resp_vld_q) begin
      resp_data_q <= resp_ch;
      resp_vld_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Interrupts: sticky events, write one to clear, set wins over clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_o <= 1'b0;
    end else begin
      if (wr_acc && paddr_i == ADDR_IRQ_MASK && pstrb_i[0]) begin
        irq_mask_q <= pwdata_i[IRQ_W-1:0];
      end
      irq_stat_q[IRQ_RESP_BIT] <= (irq_stat_q[IRQ_RESP_BIT] &
        ~(wr_acc && paddr_i == ADDR_IRQ_STAT && pstrb_i[0] && pwdata_i[IRQ_RESP_BIT])) |
        (resp_kind_q != RSP_NONE && !resp_vld_q && !pop);
      irq_stat_q[IRQ_ERR_BIT] <= (irq_stat_q[IRQ_ERR_BIT] &
        ~(wr_acc && paddr_i == ADDR_IRQ_STAT && pstrb_i[0] && pwdata_i[IRQ_ERR_BIT])) |
        (fire && xk == X_BAD);
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ==========================================================================
  // Front panel
  assign press = btn_s & ~btn_prev_q;

  // Display-select counter wraps naturally at three bits
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      btn_prev_q <= 1'b0;
      sel_q <= '0;
    end else begin
      btn_prev_q <= btn_s;
      if (press) begin
        sel_q <= sel_q + 3'h1;
      end
    end
  end

  // Message flash timer, loaded by the reset command
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flash_q <= '0;
    end else if (fire && xk == X_RST) begin
      flash_q <= FLASH_W'(FLASH_CYC - 1);
    end else if (flash_q != '0) begin
      flash_q <= flash_q - FLASH_W'(1);
    end
  end

  // Selected window of ten drivers; sel 0 shows drivers 0 to 9
  assign led_view = {8'h00, closed_q} >> (7'(sel_q) * 7'(NUM_REL_LED));

  // A latched error blanks every lamp but error and power
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      power_indicator_o <= 1'b1;
      message_indicator_o <= 1'b0;
      error_indicator_o <= 1'b0;
      enable_indicator_o <= 1'b0;
      relay_status_indicator_o <= '0;
      display_count_bit_weight1_o <= 1'b0;
      display_count_bit_weight2_o <= 1'b0;
      display_count_bit_weight4_o <= 1'b0;
    end else begin
      power_indicator_o <= 1'b1;
      error_indicator_o <= err_q;
      message_indicator_o <= ~err_q & (flash_q != '0);
      enable_indicator_o <= ~err_q & enabled_q;
      relay_status_indicator_o <= err_q ? '0 : led_view[NUM_REL_LED-1:0];
      display_count_bit_weight1_o <= ~err_q & sel_q[0];
      display_count_bit_weight2_o <= ~err_q & sel_q[1];
      display_count_bit_weight4_o <= ~err_q & sel_q[2];
    end
  end

  // ==========================================================================
  // Assertions
  err_query_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fire && xk == X_ERR_Q && !err_q && resp_kind_q == RSP_NONE |=> resp_kind_q == RSP_NOERR)
    else $error("error query without latched error did not answer no-error");
  disabled_off_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !enabled_q |=> relay_drive_o == '0)
    else $error("driver conducts while outputs disabled");
  enabled_on_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    enabled_q |=> relay_drive_o == $past(closed_q))
    else $error("enabled drivers do not follow close state");
  msg_flash_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fire && xk == X_RST |-> ##2 message_indicator_o && !error_indicator_o [*3])
    else $error("message indicator not lit after reset command");
  err_lamp_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fire && xk == X_BAD |-> ##2 error_indicator_o && !enable_indicator_o && relay_status_indicator_o == '0)
    else $error("error lamp state wrong after bad command");
  enb_lamp_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fire && xk == X_EN && !err_q |-> ##2 enable_indicator_o && !error_indicator_o)
    else $error("enable lamp not lit after enable command");
  sel_count_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    press |=> sel_q == $past(sel_q) + 3'h1)
    else $error("display counter did not advance on press");
  open_one_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fire && xk == X_OPEN |=> closed_q == ($past(closed_q) & ~$past(onehot)))
    else $error("open command changed wrong drivers");
  busy_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    resp_kind_q != RSP_NONE |=> !cmd_pend_q)
    else $error("command accepted while answer pending");

endmodule
`default_nettype wire

// >>> rdcc_commander.sv
// Commander model: sends ASCII lines and reads answers over APB word serial
`timescale 1ns/100ps
`default_nettype none
module rdcc_commander (
  // Clock
  input wire logic ref_clk_i,
  // APB master
  output logic [7:0] paddr_o = 8'h00,
  output logic psel_o = 1'b0,
  output logic penable_o = 1'b0,
  output logic pwrite_o = 1'b0,
  output logic [31:0] pwdata_o = 32'h0,
  output logic [3:0] pstrb_o = 4'h1,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  import rdcc_pkg::*;
  logic [31:0] rd = 32'h0;
  logic slv_err = 1'b0;

  // ==========================================
  // One transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge ref_clk_i);
    penable_o <= 1'b1;
    do @(posedge ref_clk_i); while (pready_i !== 1'b1);
    rd = prdata_i;
    slv_err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask

  // Polling handshake: no cycle count assumed, bench timeout ends a hang
  task automatic poll(input int b);
    do xfer(1'b0, ADDR_STAT, 32'h0); while (rd[b] !== 1'b1);
  endtask

  // Send one line, one character per word, line feed appended
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      poll(STAT_CMD_RDY_BIT);
      xfer(1'b1, ADDR_CMD, {24'h0, s[i]});
    end
    poll(STAT_CMD_RDY_BIT);
    xfer(1'b1, ADDR_CMD, {24'h0, CH_LF});
  endtask

  // Read one answer line, terminator included
  task automatic get(output logic [255:0] t);
    t = '0;
    do begin
      poll(STAT_RESP_VLD_BIT);
      xfer(1'b0, ADDR_RESP, 32'h0);
      t = {t[247:0], rd[7:0]};
    end while (rd[7:0] !== CH_LF);
  endtask
endmodule
`default_nettype wire

// >>> rdcc_top_test.sv
// Self-checking testbench of the relay driver command controller
`timescale 1ns/100ps
`default_nettype none
module rdcc_top_test;
  import rdcc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [NUM_DRV-1:0] drive;
  logic [NUM_DRV-1:0] sense = '0;
  logic btn = 1'b0;
  logic bad_sense = 1'b0;
  logic power_indicator, message_indicator, err, enable_indicator, w1, w2, w4;
  logic [NUM_REL_LED-1:0] rel;
  logic [16:0] leds;
  logic [255:0] t;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  assign leds = {power_indicator, message_indicator, err, enable_indicator, rel, w4, w2, w1};

  // ==========================================
  // Design and commander; short flash count keeps the run brief
  rdcc_top #(.FLASH_CYC(20)) rdcc_top_inst (.ref_clk_i(clk), .rst_i(rst), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .relay_drive_o(drive),
    .drv_sense_i(sense), .display_select_button_i(btn), .power_indicator_o(power_indicator),
    .message_indicator_o(message_indicator), .error_indicator_o(err), .enable_indicator_o(enable_indicator),
    .relay_status_indicator_o(rel), .display_count_bit_weight1_o(w1),
    .display_count_bit_weight2_o(w2), .display_count_bit_weight4_o(w4));
  rdcc_commander rdcc_commander_inst (.ref_clk_i(clk), .paddr_o(paddr), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .pwdata_o(pwdata), .pstrb_o(pstrb),
    .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

  // Clock at 125 MHz
  initial begin
    forever #4 clk = ~clk;
  end
  // Sense lines echo the drivers, one bit broken on demand
  always @(posedge clk) sense <= drive ^ {{(NUM_DRV-1){1'b0}}, bad_sense};
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic line(input string s);
    rdcc_commander_inst.send(s);
    repeat (6) @(posedge clk);
  endtask
  task automatic ask(input string s, input logic [255:0] exp);
    rdcc_commander_inst.send(s);
    rdcc_commander_inst.get(t);
    check(t, exp);
  endtask

  // ==========================================
  // Scenarios; lower-case command text also exercises case folding
  task automatic power_up();
    check(leds, 17'h10000);
    ask("qer", "NO ERRORS\r\n");
    ask("qen", "0\r\n");
    ask("qtg", "0\r\n");
    check(drive, '0);
  endtask
  task automatic drivers();
    line("d;cb0");
    check(drive, '0);
    line("E");
    check(drive, 72'hff);
    check(enable_indicator, 1'b1);
    ask("qrb", "0000000000000000FF\r\n");
    line("O0");
    ask("qrb", "0000000000000000FE\r\n");
    line("o1;C71");
    ask("qrb", "8000000000000000FC\r\n");
    check(drive, 72'h8000000000000000fc);
  endtask
  // Reset command: bounded waits for the flash to start and end
  task automatic do_reset();
    int n;
    rdcc_commander_inst.send("R");
    n = 0;
    while (message_indicator !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    check(message_indicator, 1'b1);
    while (message_indicator !== 1'b0 && n < 60) begin
      @(posedge clk);
      n++;
    end
    check(leds, 17'h10000);
    check(drive, '0);
  endtask
  task automatic lamps();
    line("E");
    check(leds, 17'h12000);
    line("d;cb0;cb1");
    check(leds, 17'h11ff8);
    do_reset();
  endtask
  task automatic bad_cmd();
    line("A");
    check(leds, 17'h14000);
    check(irq, 1'b0);
    rdcc_commander_inst.xfer(1'b1, ADDR_IRQ_MASK, 32'h2);
    repeat (3) @(posedge clk);
    check(irq, 1'b1);
    rdcc_commander_inst.xfer(1'b1, ADDR_IRQ_STAT, 32'h3);
    repeat (3) @(posedge clk);
    check(irq, 1'b0);
    rdcc_commander_inst.xfer(1'b0, 8'h40, 32'h0);
    check(rdcc_commander_inst.slv_err, 1'b1);
    check(leds, 17'h14000);
    do_reset();
  endtask
  task automatic buttons();
    for (int k = 1; k <= 8; k++) begin
      btn <= 1'b1;
      repeat (5) @(posedge clk);
      btn <= 1'b0;
      repeat (5) @(posedge clk);
      check({w4, w2, w1}, k[2:0]);
    end
  endtask
  task automatic self_test();
    ask("S", "READY\r\n");
    bad_sense <= 1'b1;
    repeat (5) @(posedge clk);
    ask("S", "SELF TEST FAIL\r\n");
    bad_sense <= 1'b0;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    power_up();
    drivers();
    do_reset();
    lamps();
    bad_cmd();
    buttons();
    self_test();
    wrap_up();
  end
endmodule
`default_nettype wire
